// ==== exec_pkg.sv ====
// Package for the integer execution unit: widths, opcodes, carriers
package exec_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned SET_COUNT = 8;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned SET_W = 3;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [31:0] RESET_PC = 32'h00000000;
  localparam logic [31:0] PC_STEP = 32'h00000004;
  localparam logic [2:0] RESET_SET = 3'h0;
  localparam logic [5:0] DIV_CYCLES = 6'h20;
  localparam logic [5:0] MUL_CYCLES = 6'h05;
  localparam logic [5:0] RESET_COUNT = 6'h00;
  localparam logic [4:0] LANE_SHIFT_POS = 5'h03;

  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_AND = 5'h02, OP_OR = 5'h03,
    OP_XOR = 5'h04, OP_NOR = 5'h05, OP_SLL = 5'h06, OP_SRL = 5'h07,
    OP_SRA = 5'h08, OP_SLT = 5'h09, OP_SLTU = 5'h0A,
    OP_COUNT_ZEROS = 5'h0B, OP_COUNT_ONES = 5'h0C,
    OP_DSP_SHRA = 5'h0D, OP_DSP_CMP = 5'h0E,
    OP_LOAD = 5'h0F, OP_STORE = 5'h10, OP_LUI = 5'h11
  } alu_op_type;

  typedef enum logic [2:0] {
    BR_NONE = 3'h0, BR_EQ = 3'h1, BR_NE = 3'h2, BR_LTZ = 3'h3,
    BR_GEZ = 3'h4, BR_JUMP = 3'h5, BR_REG = 3'h6
  } branch_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0, SIZE_HALF = 2'h1, SIZE_WORD = 2'h2
  } mem_size_type;

  typedef enum logic [1:0] {
    MD_NONE = 2'h0, MD_MUL = 2'h1, MD_DIV = 2'h2
  } md_kind_type;

  typedef enum logic [1:0] {
    MD_IDLE = 2'h0, MD_BUSY_MUL = 2'h1, MD_BUSY_DIV = 2'h2
  } md_state_type;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    alu_op_type op;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dest;
    logic write_en;
    logic use_imm;
    logic [31:0] imm;
    branch_type branch;
    mem_size_type size;
    logic load_signed;
    md_kind_type md_kind;
  } issue_type;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [31:0] value;
  } result_type;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] lanes;
  } mem_req_type;

endpackage : exec_pkg

// ==== integer_execution_unit.sv ====
// Integer execution unit: banked register file, ALU, branch and aligners
// ---------------------------------------------------------------
// Operation
// - Logic, shift, add, subtract take one cycle; memory via load/store.
// - Thirty-two general purpose registers of 32 bits each.
// - Seven shadow sets of thirty-two registers beside the primary set.
// - Two reads and one write per cycle.
// - Read paths fully bypassed from pending and current results.
// - Dedicated 32-bit adder forms load and store data addresses.
// - Separate unit forms the next instruction address.
// - Dedicated logic evaluates branch conditions and targets.
// - Counts leading zeros and leading ones of an operand.
// - Store data replicated across byte lanes; lane enables chosen by address.
// - Separate DSP ALU for arithmetic shift and compare.
// - Multiply/divide keeps advancing while integer pipeline stalls.
// - New multiply/divide during a divide stalls the integer pipeline.
// ---------------------------------------------------------------
`timescale 1ns/10ps
module integer_execution_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Issue from decode and pipeline control
  input wire exec_pkg::issue_type issue,
  input wire logic [2:0] set_select,
  input wire logic ext_stall,
  // Load return data
  input wire logic [31:0] load_data,
  // Multiply/divide completion from the partner datapath
  input wire exec_pkg::result_type md_result,
  // Outputs
  output exec_pkg::result_type wb_out,
  output exec_pkg::mem_req_type mem_out,
  output logic [31:0] fetch_pc,
  output logic branch_taken,
  output logic integer_pipeline_stall,
  output logic multiply_divide_unit_busy
);
  import exec_pkg::*;

  // ---------------------------------------------------------------
  // Register file storage
  // ---------------------------------------------------------------
  // eight sets of 32
  logic [31:0] gpr_reg [SET_COUNT*REG_COUNT];
  logic [2:0] set_reg;
  result_type pend_reg;
  logic [1:0] pend_lane_reg;
  mem_size_type pend_size_reg;
  logic pend_signed_reg;
  logic pend_is_load_reg;
  md_state_type md_state_reg;
  logic [5:0] md_count_reg;
  logic [31:0] pc_reg;
  function automatic logic [7:0] slot(input logic [2:0] s,
                                      input logic [4:0] r);
    slot = {s, r};
  endfunction : slot

  // ---------------------------------------------------------------
  // Load aligner for the pending writeback
  // ---------------------------------------------------------------
  wire [4:0] load_sh = {pend_lane_reg, 3'h0};
  wire [31:0] load_shift = load_data >> load_sh;
  wire [31:0] load_val =
    (pend_size_reg == SIZE_BYTE) ?
      {{24{pend_signed_reg & load_shift[7]}}, load_shift[7:0]} :
    (pend_size_reg == SIZE_HALF) ?
      {{16{pend_signed_reg & load_shift[15]}}, load_shift[15:0]} :
      load_data;
  wire [31:0] pend_val = pend_is_load_reg ? load_val : pend_reg.value;

  // Writeback choice: multiply/divide result wins the single port
  // one write port
  wire md_wins = md_result.valid && md_result.dest != 5'h00;
  wire pend_ok = pend_reg.valid && pend_reg.dest != 5'h00;
  wire wr_en = md_wins || pend_ok;
  wire [4:0] wr_idx = md_wins ? md_result.dest : pend_reg.dest;
  wire [31:0] wr_val = md_wins ? md_result.value : pend_val;
  // A writeback that lost the port is retried by holding the stage
  wire wb_blocked = md_wins && pend_ok;

  // ---------------------------------------------------------------
  // Read ports with bypass
  // ---------------------------------------------------------------
  // set select
  wire [31:0] raw_a = gpr_reg[slot(set_reg, issue.src_a)];
  wire [31:0] raw_b = gpr_reg[slot(set_reg, issue.src_b)];
  wire [31:0] op_a = (issue.src_a == 5'h00) ? RESET_WORD :
                     (wr_en && wr_idx == issue.src_a) ? wr_val : raw_a;
  wire [31:0] op_b_reg = (issue.src_b == 5'h00) ? RESET_WORD :
                     (wr_en && wr_idx == issue.src_b) ? wr_val : raw_b;
  wire [31:0] op_b = issue.use_imm ? issue.imm : op_b_reg;
  // Pending load that lost the write port to multiply/divide also stalls
  wire load_use = pend_reg.valid && pend_is_load_reg && wb_blocked;

  // ---------------------------------------------------------------
  // ALU, counters and DSP block
  // ---------------------------------------------------------------
  // single cycle ALU
  wire [31:0] sum = op_a + op_b;
  wire [31:0] diff = op_a - op_b;
  wire [4:0] shamt = op_b[4:0];
  wire signed_lt = $signed(op_a) < $signed(op_b);
  logic [5:0] lead_zeros;
  logic [5:0] lead_ones;
  always_comb begin
    lead_zeros = 6'h20;
    lead_ones = 6'h20;
    for (int i = 0; i < 32; i++) begin
      if (op_a[i]) lead_zeros = 6'(31 - i);
      if (!op_a[i]) lead_ones = 6'(31 - i);
    end
  end
  wire [31:0] dsp_shra = $signed(op_a) >>> shamt;
  wire [31:0] dsp_cmp = {29'h0, signed_lt, op_a == op_b,
                         !signed_lt && op_a != op_b};
  wire [31:0] data_addr = op_a + issue.imm;
  wire [1:0] lane = data_addr[1:0];
  logic [31:0] alu_val;
  always_comb begin
    unique case (issue.op)
      OP_ADD: alu_val = sum;
      OP_SUB: alu_val = diff;
      OP_AND: alu_val = op_a & op_b;
      OP_OR: alu_val = op_a | op_b;
      OP_XOR: alu_val = op_a ^ op_b;
      OP_NOR: alu_val = ~(op_a | op_b);
      OP_SLL: alu_val = op_a << shamt;
      OP_SRL: alu_val = op_a >> shamt;
      OP_SRA: alu_val = dsp_shra;
      OP_SLT: alu_val = {31'h0, signed_lt};
      OP_SLTU: alu_val = {31'h0, op_a < op_b};
      OP_COUNT_ZEROS: alu_val = {26'h0, lead_zeros};
      OP_COUNT_ONES: alu_val = {26'h0, lead_ones};
      OP_DSP_SHRA: alu_val = dsp_shra;
      OP_DSP_CMP: alu_val = dsp_cmp;
      OP_LUI: alu_val = {op_b[15:0], 16'h0};
      default: alu_val = data_addr;
    endcase
  end
  // Replicated data fills every lane, so no store shifter is needed
  // store aligner
  wire [31:0] st_data =
    (issue.size == SIZE_BYTE) ? ({4{op_b_reg[7:0]}}) :
    (issue.size == SIZE_HALF) ? ({2{op_b_reg[15:0]}}) : op_b_reg;
  wire [3:0] st_lanes =
    (issue.size == SIZE_BYTE) ? (4'h1 << lane) :
    (issue.size == SIZE_HALF) ? (lane[1] ? 4'hC : 4'h3) : 4'hF;

  // ---------------------------------------------------------------
  // Branch decision and next address
  // ---------------------------------------------------------------
  // branch logic
  wire [31:0] br_target = pc_reg + PC_STEP + {issue.imm[29:0], 2'h0};
  logic br_cond;
  always_comb begin
    unique case (issue.branch)
      BR_EQ: br_cond = op_a == op_b_reg;
      BR_NE: br_cond = op_a != op_b_reg;
      BR_LTZ: br_cond = op_a[31];
      BR_GEZ: br_cond = !op_a[31];
      BR_JUMP: br_cond = 1'b1;
      BR_REG: br_cond = 1'b1;
      default: br_cond = 1'b0;
    endcase
  end
  wire [31:0] jump_to = (issue.branch == BR_REG) ? op_a :
                        (issue.branch == BR_JUMP) ?
                        {pc_reg[31:28], issue.imm[25:0], 2'h0} : br_target;

  // ---------------------------------------------------------------
  // Multiply/divide tracking and stall
  // ---------------------------------------------------------------
  wire md_issue = issue.valid && issue.md_kind != MD_NONE;
  wire div_block = md_issue && md_state_reg == MD_BUSY_DIV;
  wire stall = ext_stall || div_block || wb_blocked || load_use;
  wire go = issue.valid && !stall;
  wire [31:0] pc_next = (go && br_cond) ? jump_to :
                        stall ? pc_reg : pc_reg + PC_STEP;
  wire md_done = md_count_reg == 6'h01 || md_result.valid;
  md_state_type md_next;
  always_comb begin
    md_next = md_state_reg;
    unique case (md_state_reg)
      MD_IDLE: if (go && issue.md_kind == MD_DIV) md_next = MD_BUSY_DIV;
        else if (go && issue.md_kind == MD_MUL) md_next = MD_BUSY_MUL;
      MD_BUSY_MUL: if (md_done) md_next = MD_IDLE;
      MD_BUSY_DIV: if (md_done) md_next = MD_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Register file write
  // ---------------------------------------------------------------
  // single write port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int k = 0; k < SET_COUNT*REG_COUNT; k++) gpr_reg[k] <= RESET_WORD;
    end else if (wr_en) begin
      gpr_reg[slot(set_reg, wr_idx)] <= wr_val;
    end
  end

  // Set switch waits for an empty writeback stage so pending ALU/load writes land in the old set
  // set switch
  always_ff @(posedge core_clk) begin
    if (reset) set_reg <= RESET_SET;
    else if (!pend_reg.valid) set_reg <= set_select;
  end

  // Execute to writeback stage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_reg <= '0;
      pend_lane_reg <= 2'h0;
      pend_size_reg <= SIZE_WORD;
      pend_signed_reg <= 1'b0;
      pend_is_load_reg <= 1'b0;
    end else if (!wb_blocked) begin
      pend_reg.valid <= go && issue.write_en && issue.md_kind == MD_NONE;
      pend_reg.dest <= issue.dest;
      pend_reg.value <= alu_val;
      pend_lane_reg <= lane;
      pend_size_reg <= issue.size;
      pend_signed_reg <= issue.load_signed;
      pend_is_load_reg <= issue.op == OP_LOAD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      md_state_reg <= MD_IDLE;
      md_count_reg <= RESET_COUNT;
    end else begin
      md_state_reg <= md_next;
      if (md_state_reg == MD_IDLE && go && issue.md_kind == MD_DIV)
        md_count_reg <= DIV_CYCLES;
      else if (md_state_reg == MD_IDLE && go && issue.md_kind == MD_MUL)
        md_count_reg <= MUL_CYCLES;
      else if (md_next == MD_IDLE) md_count_reg <= RESET_COUNT;
      else if (md_count_reg != RESET_COUNT)
        md_count_reg <= md_count_reg - 6'h01;
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_reg <= RESET_PC;
      fetch_pc <= RESET_PC;
      branch_taken <= 1'b0;
      mem_out <= '0;
      wb_out <= '0;
      integer_pipeline_stall <= 1'b0;
      multiply_divide_unit_busy <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      fetch_pc <= pc_next;
      branch_taken <= go && br_cond;
      mem_out.req <= go && (issue.op == OP_LOAD || issue.op == OP_STORE);
      mem_out.write <= go && issue.op == OP_STORE;
      mem_out.addr <= data_addr;
      mem_out.wdata <= st_data;
      mem_out.lanes <= (issue.op == OP_STORE) ? st_lanes : 4'hF;
      wb_out.valid <= wr_en;
      wb_out.dest <= wr_idx;
      wb_out.value <= wr_val;
      integer_pipeline_stall <= stall;
      multiply_divide_unit_busy <= md_next != MD_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_div_stall;
    @(posedge core_clk) disable iff (reset)
      div_block |=> integer_pipeline_stall;
  endproperty
  a_div_stall: assert property (p_div_stall) else $error("stall");
  property p_md_runs;
    @(posedge core_clk) disable iff (reset)
      (md_state_reg == MD_BUSY_DIV && ext_stall && md_count_reg > 6'h01
       && !md_result.valid) |=> md_count_reg == $past(md_count_reg) - 6'h01;
  endproperty
  a_md_runs: assert property (p_md_runs) else $error("md froze");
  property p_reg_zero;
    @(posedge core_clk) disable iff (reset)
      (issue.src_a == 5'h00) |-> op_a == RESET_WORD;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("zero reg");
  property p_bypass;
    @(posedge core_clk) disable iff (reset)
      (wr_en && issue.src_a == wr_idx && wr_idx != 5'h00) |-> op_a == wr_val;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass missed");
  property p_st_lanes;
    @(posedge core_clk) disable iff (reset)
      (go && issue.op == OP_STORE && issue.size == SIZE_WORD)
      |=> mem_out.write && mem_out.lanes == 4'hF;
  endproperty
  a_st_lanes: assert property (p_st_lanes) else $error("lanes");
  property p_addr;
    @(posedge core_clk) disable iff (reset)
      go && issue.op == OP_LOAD
      |=> mem_out.addr == $past(op_a) + $past(issue.imm);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_pc;
    @(posedge core_clk) disable iff (reset)
      (!stall && !(go && br_cond)) |=> fetch_pc == $past(pc_reg) + PC_STEP;
  endproperty
  a_pc: assert property (p_pc) else $error("pc step");
  property p_branch;
    @(posedge core_clk) disable iff (reset)
      (go && issue.branch == BR_JUMP) |=> branch_taken;
  endproperty
  a_branch: assert property (p_branch) else $error("no jump");
  property p_clz;
    @(posedge core_clk) disable iff (reset)
      (op_a == 32'h00000001) |-> lead_zeros == 6'h1F && lead_ones == 6'h00;
  endproperty
  a_clz: assert property (p_clz) else $error("count wrong");
  c_div: cover property (@(posedge core_clk) div_block);
  c_branch: cover property (@(posedge core_clk) go && br_cond);
  c_store: cover property (@(posedge core_clk) mem_out.write);
  c_fwd: cover property (@(posedge core_clk) wr_en && issue.src_a == wr_idx);

endmodule : integer_execution_unit

// ==== md_partner.sv ====
// Behavioural multiply/divide datapath that answers the execution unit
`timescale 1ns/10ps
module md_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bench command: each toggle of fire starts one operation
  input wire logic fire,
  input wire logic [4:0] fire_dest,
  input wire logic [31:0] fire_value,
  input wire logic [5:0] fire_delay,
  // Completion towards the execution unit
  output exec_pkg::result_type md_result
);
  import exec_pkg::*;
  logic fire_reg;
  logic [5:0] count_reg;
  result_type hold_reg;
  // counts regardless of stalls
  // The datapath never sees the integer stall, so it keeps advancing.
  // Idle cycles show inverted data so stale values cannot pass.
  always_ff @(posedge core_clk) begin
    fire_reg <= fire;
    md_result <= {1'b0, ~hold_reg.dest, ~hold_reg.value};
    if (reset) begin
      count_reg <= 6'h00;
      hold_reg <= '0;
    end else if (fire !== fire_reg) begin
      count_reg <= fire_delay;
      hold_reg <= {1'b1, fire_dest, fire_value};
    end else if (count_reg != 6'h00) begin
      count_reg <= count_reg - 6'h01;
      if (count_reg == 6'h01) md_result <= hold_reg;
    end
  end
endmodule : md_partner

// ==== integer_execution_unit_tb.sv ====
// Self-checking testbench for the integer execution unit
`timescale 1ns/10ps
module integer_execution_unit_tb;
  import exec_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  issue_type issue = '0;
  logic [2:0] set_select = 3'h0;
  logic ext_stall = 1'b0;
  logic [31:0] load_data = 32'h00000000;
  result_type md_result;
  result_type wb_out;
  mem_req_type mem_out;
  logic [31:0] fetch_pc;
  logic branch_taken;
  logic integer_pipeline_stall;
  logic multiply_divide_unit_busy;
  logic fire = 1'b0;
  logic [4:0] fire_dest = 5'h00;
  logic [31:0] fire_value = 32'h00000000;
  logic [5:0] fire_delay = 6'h01;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  result_type wb_q[$];
  mem_req_type mem_q[$];

  integer_execution_unit dut_u (.core_clk(core_clk), .reset(reset),
    .issue(issue), .set_select(set_select), .ext_stall(ext_stall),
    .load_data(load_data), .md_result(md_result), .wb_out(wb_out),
    .mem_out(mem_out), .fetch_pc(fetch_pc), .branch_taken(branch_taken),
    .integer_pipeline_stall(integer_pipeline_stall),
    .multiply_divide_unit_busy(multiply_divide_unit_busy));
  md_partner partner_u (.core_clk(core_clk), .reset(reset), .fire(fire),
    .fire_dest(fire_dest), .fire_value(fire_value),
    .fire_delay(fire_delay), .md_result(md_result));

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  // Log register writes and memory requests; cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wb_out.valid === 1'b1) wb_q.push_back(wb_out);
    if (mem_out.req === 1'b1) mem_q.push_back(mem_out);
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic issue_type mk(alu_op_type op, logic [4:0] a,
      logic [4:0] b, logic [4:0] d, logic [31:0] imm, logic use_imm);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.src_a = a;
    mk.src_b = b;
    mk.dest = d;
    mk.write_en = (d != 5'h00);
    mk.use_imm = use_imm;
    mk.imm = imm;
    mk.size = SIZE_WORD;
  endfunction : mk

  // Hold a request until an edge takes it; the stall flag lags one cycle
  task automatic put(input issue_type i);
    int n;
    issue = i;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk);
      #1;
      if (integer_pipeline_stall === 1'b0) break;
    end
    chk(n < 60, 1'b1);
  endtask : put

  task automatic idle(input int c);
    issue.valid = 1'b0;
    repeat (c) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [4:0] d, input logic [31:0] v);
    put(mk(OP_ADD, 5'h00, 5'h00, d, v, 1'b1));
  endtask : wr

  task automatic wbx(input logic [4:0] d, input logic [31:0] v,
                     input logic any = 1'b0);
    result_type r;
    for (int n = 0; n < 40 && wb_q.size() == 0; n++) begin
      @(posedge core_clk);
      #1;
    end
    r = (wb_q.size() != 0) ? wb_q.pop_front() : '0;
    chk(r.dest, d);
    if (!any) chk(r.value, v);
  endtask : wbx

  task automatic memx(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] l, input logic w);
    mem_req_type m;
    for (int n = 0; n < 20 && mem_q.size() == 0; n++) begin
      @(posedge core_clk);
      #1;
    end
    m = (mem_q.size() != 0) ? mem_q.pop_front() : '0;
    chk(m.addr, a);
    chk(m.write, w);
    if (w) chk(m.wdata, d);
    if (w) chk(m.lanes, l);
  endtask : memx

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // back-to-back ops on fresh results
  task automatic t_alu();
    alu_op_type ops[12] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR,
      OP_SLL, OP_SRL, OP_SRA, OP_SLT, OP_SLTU, OP_DSP_SHRA};
    logic [31:0] a = 32'hF0F01234;
    logic [31:0] b = 32'h00000004;
    logic [31:0] e;
    int c0;
    wr(5'h01, a);
    wr(5'h02, b);
    c0 = cycles;
    foreach (ops[k]) put(mk(ops[k], 5'h01, 5'h02, 5'(k + 10), 0, 1'b0));
    chk(cycles - c0, 12);
    idle(2);
    wbx(5'h01, a);
    wbx(5'h02, b);
    foreach (ops[k]) begin
      case (ops[k])
        OP_ADD: e = a + b;
        OP_SUB: e = a - b;
        OP_AND: e = a & b;
        OP_OR: e = a | b;
        OP_XOR: e = a ^ b;
        OP_NOR: e = ~(a | b);
        OP_SLL: e = a << b[4:0];
        OP_SRL: e = a >> b[4:0];
        OP_SLT: e = {31'h0, $signed(a) < $signed(b)};
        OP_SLTU: e = {31'h0, a < b};
        default: e = $unsigned($signed(a) >>> b[4:0]);
      endcase
      wbx(5'(k + 10), e);
    end
  endtask : t_alu

  task automatic t_count();
    wr(5'h03, 32'h00010000);
    put(mk(OP_COUNT_ZEROS, 5'h03, 5'h00, 5'h0A, 0, 1'b0));
    put(mk(OP_NOR, 5'h03, 5'h00, 5'h04, 0, 1'b0));
    put(mk(OP_COUNT_ONES, 5'h04, 5'h00, 5'h0B, 0, 1'b0));
    put(mk(OP_COUNT_ZEROS, 5'h00, 5'h00, 5'h0C, 0, 1'b0));
    put(mk(OP_DSP_CMP, 5'h03, 5'h04, 5'h0D, 0, 1'b0));
    put(mk(OP_LUI, 5'h00, 5'h00, 5'h0E, 32'h0000ABCD, 1'b1));
    wr(5'h0F, 32'h00000001);
    put(mk(OP_COUNT_ZEROS, 5'h0F, 5'h00, 5'h10, 0, 1'b0));
    idle(2);
    wbx(5'h03, 32'h00010000);
    wbx(5'h0A, 32'h0000000F);
    wbx(5'h04, 32'hFFFEFFFF);
    wbx(5'h0B, 32'h0000000F);
    wbx(5'h0C, 32'h00000020);
    wbx(5'h0D, 0, 1'b1);
    wbx(5'h0E, 32'hABCD0000);
    wbx(5'h0F, 32'h00000001);
    wbx(5'h10, 32'h0000001F);
  endtask : t_count

  // shadow set keeps its own copy
  task automatic t_sets();
    wr(5'h05, 32'hA5A50001);
    idle(3);
    wbx(5'h05, 32'hA5A50001);
    set_select = 3'h7;
    idle(3);
    put(mk(OP_OR, 5'h05, 5'h00, 5'h1F, 0, 1'b0));
    wr(5'h05, 32'h5A5A0007);
    idle(3);
    wbx(5'h1F, RESET_WORD);
    wbx(5'h05, 32'h5A5A0007);
    set_select = 3'h0;
    idle(3);
    put(mk(OP_OR, 5'h05, 5'h00, 5'h1F, 0, 1'b0));
    idle(3);
    wbx(5'h1F, 32'hA5A50001);
  endtask : t_sets

  // address carry and store lanes, then a signed and an unsigned load
  task automatic t_mem();
    mem_size_type sz[3] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD};
    logic [31:0] ofs[3] = '{4, 5, 7};
    logic [31:0] wd[3] = '{32'hC4C4C4C4, 32'h33C433C4, 32'h112233C4};
    logic [3:0] ln[3] = '{4'h2, 4'hC, 4'hF};
    issue_type i;
    load_data = 32'h80112233;
    wr(5'h07, 32'h00000FFD);
    wr(5'h08, 32'h112233C4);
    foreach (sz[k]) begin
      i = mk(OP_STORE, 5'h07, 5'h08, 5'h00, ofs[k], 1'b1);
      i.size = sz[k];
      put(i);
    end
    i = mk(OP_LOAD, 5'h07, 5'h00, 5'h09, 32'h00000006, 1'b1);
    i.size = SIZE_BYTE;
    i.load_signed = 1'b1;
    put(i);
    i.size = SIZE_HALF;
    i.load_signed = 1'b0;
    i.imm = 32'h00000005;
    i.dest = 5'h0A;
    put(i);
    idle(3);
    foreach (sz[k]) memx(32'h00000FFD + ofs[k], wd[k], ln[k], 1'b1);
    memx(32'h00001003, 0, 4'h0, 1'b0);
    memx(32'h00001002, 0, 4'h0, 1'b0);
    wbx(5'h07, 32'h00000FFD);
    wbx(5'h08, 32'h112233C4);
    wbx(5'h09, 32'hFFFFFF80);
    wbx(5'h0A, 32'h00008011);
  endtask : t_mem

  // every branch kind once, some taken and some not
  task automatic t_branch();
    branch_type bk[7] = '{BR_NONE, BR_EQ, BR_NE, BR_LTZ, BR_GEZ, BR_JUMP,
      BR_REG};
    logic [4:0] ba[7] = '{2, 2, 2, 1, 1, 0, 2};
    logic [31:0] bi[7] = '{4, 3, 3, 32'hFFFFFFFE, 3, 32'h00000040, 0};
    logic bt[7] = '{0, 1, 0, 1, 0, 1, 1};
    issue_type i;
    logic [31:0] pc0;
    logic [31:0] tgt;
    wr(5'h01, 32'hFFFFFFF0);
    wr(5'h02, 32'h00000200);
    idle(3);
    wbx(5'h01, 32'hFFFFFFF0);
    wbx(5'h02, 32'h00000200);
    foreach (bk[k]) begin
      pc0 = fetch_pc;
      i = mk(OP_ADD, ba[k], ba[k], 5'h00, bi[k], 1'b0);
      i.branch = bk[k];
      tgt = pc0 + PC_STEP + (bi[k] << 2);
      if (bk[k] == BR_JUMP) tgt = {pc0[31:28], bi[k][25:0], 2'h0};
      if (bk[k] == BR_REG) tgt = 32'h00000200;
      put(i);
      chk(branch_taken, bt[k]);
      chk(fetch_pc, bt[k] ? tgt : pc0 + PC_STEP);
    end
    idle(1);
  endtask : t_branch

  task automatic kick(input logic [4:0] d, input logic [31:0] v,
                      input logic [5:0] n);
    fire_dest = d;
    fire_value = v;
    fire_delay = n;
    fire = ~fire;
  endtask : kick

  // divide through a stall, then a blocked multiply
  task automatic t_md();
    issue_type dv;
    issue_type ml;
    int c0;
    dv = mk(OP_ADD, 5'h01, 5'h02, 5'h06, 0, 1'b0);
    dv.md_kind = MD_DIV;
    ml = dv;
    ml.md_kind = MD_MUL;
    ml.dest = 5'h07;
    put(dv);
    kick(5'h06, 32'h00000777, 6'h0C);
    ext_stall = 1'b1;
    idle(1);
    chk(multiply_divide_unit_busy, 1'b1);
    wbx(5'h06, 32'h00000777);
    chk(integer_pipeline_stall, 1'b1);
    ext_stall = 1'b0;
    idle(2);
    chk(multiply_divide_unit_busy, 1'b0);
    put(dv);
    kick(5'h06, 32'h00000999, 6'h14);
    c0 = cycles;
    put(ml);
    chk(cycles - c0 > 15, 1'b1);
    kick(5'h07, 32'h00000042, MUL_CYCLES);
    idle(1);
    wbx(5'h06, 32'h00000999);
    wbx(5'h07, 32'h00000042);
  endtask : t_md

  // Main sequence: reset for 12 cycles, then every scenario
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    chk(fetch_pc, RESET_PC);
    chk(multiply_divide_unit_busy, 1'b0);
    reset = 1'b0;
    t_alu();
    t_count();
    t_sets();
    t_mem();
    t_branch();
    t_md();
    complete_run();
  end
endmodule : integer_execution_unit_tb
